/* src/rre_exec.sv */
// module: execution of the return and rotate instruction group
// Summary of operation
// RULE1 - literal subroutine exit pops pc, loads literal into accumulator, flags untouched
// RULE2 - interrupt return pops pc, sets master interrupt enable, flags untouched
// RULE3 - pending interrupt at interrupt return is serviced before main program resumes
// RULE4 - rotate left: memory byte rotated left, bit 7 to bit 0, no flags
// RULE5 - rotate left to accumulator: result in accumulator, memory kept, no flags
// RULE6 - rotate left through carry: old carry to bit 0, bit 7 to carry
// RULE7 - rotate left carry to accumulator: nine-bit rotation into accumulator, memory kept
// RULE8 - rotate right: memory byte rotated right, bit 0 to bit 7, no flags
// RULE9 - rotate right to accumulator: result in accumulator, memory kept, no flags
// RULE10 - rotate right through carry: old carry to bit 7, bit 0 to carry
// RULE11 - through-carry rotates change only carry; all operands are eight bits
`timescale 1ns/1ps
module rre_exec (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // instruction request
  input wire logic i_op_valid,
  input wire logic [3:0] i_op_code,
  input wire logic [7:0] i_literal,
  // data memory operand and write-back
  input wire logic [7:0] i_mem_rdata,
  output logic o_mem_we,
  output logic [7:0] o_mem_wdata,
  // hardware stack
  input wire logic [12:0] i_stack_top,
  output logic o_stack_pop,
  output logic o_stack_push,
  output logic [12:0] o_push_addr,
  // interrupt controller
  input wire logic i_irq_pending,
  input wire logic [12:0] i_irq_vector,
  // core state
  output logic [7:0] o_acc,
  output logic o_carry,
  output logic o_mie,
  output logic [12:0] o_pc,
  output logic o_done
);
  rre_pkg::rre_op_t op;
  logic take;
  logic next_mem_we;
  logic [7:0] next_mem_wdata;
  logic next_stack_push;
  logic [12:0] next_push_addr;
  logic [7:0] next_acc;
  logic next_carry;
  logic next_mie;
  logic [12:0] next_pc;
  logic next_done;

  rre_rot_if rot ();

  rre_rotator u_rot (
    .port(rot.rot)
  );

  function automatic logic is_return(input rre_pkg::rre_op_t code);
    return (code == rre_pkg::rre_op_subroutine_exit_with_literal) ||
           (code == rre_pkg::rre_op_return_from_interrupt);
  endfunction : is_return

  function automatic logic is_thru(input rre_pkg::rre_op_t code);
    return (code == rre_pkg::rre_op_rotate_left_through_carry) ||
           (code == rre_pkg::rre_op_rotate_left_carry_to_accumulator) ||
           (code == rre_pkg::rre_op_rotate_right_through_carry);
  endfunction : is_thru

  assign op = rre_pkg::rre_op_t'(i_op_code);
  assign take = i_op_valid;
  // pop is combinational so the stack top is consumed in the taking cycle
  assign o_stack_pop = take && is_return(op); // [RULE1] [RULE2]

  assign rot.din = i_mem_rdata; // [RULE11]
  assign rot.cin = o_carry;
  assign rot.thru = is_thru(op);
  assign rot.left = (op == rre_pkg::rre_op_rotate_left) ||
                    (op == rre_pkg::rre_op_rotate_left_to_accumulator) ||
                    (op == rre_pkg::rre_op_rotate_left_through_carry) ||
                    (op == rre_pkg::rre_op_rotate_left_carry_to_accumulator);

  always_comb begin
    next_mem_we = 1'b0;
    next_mem_wdata = o_mem_wdata;
    next_stack_push = 1'b0;
    next_push_addr = o_push_addr;
    next_acc = o_acc;
    next_carry = o_carry;
    next_mie = o_mie;
    next_pc = o_pc;
    next_done = take;
    if (take) begin
      unique case (op)
        rre_pkg::rre_op_nop: begin
          next_done = 1'b1;
        end
        rre_pkg::rre_op_subroutine_exit_with_literal: begin
          next_pc = i_stack_top; // [RULE1]
          next_acc = i_literal; // [RULE1]
        end
        rre_pkg::rre_op_return_from_interrupt: begin
          if (i_irq_pending) begin
            // enter the pending routine at once; the popped address goes back on the stack
            // so the main program resumes only after that routine returns
            next_pc = i_irq_vector; // [RULE3]
            next_stack_push = 1'b1; // [RULE3]
            next_push_addr = i_stack_top; // [RULE3]
            next_mie = rre_pkg::MIE_RST; // [RULE3]
          end else begin
            next_pc = i_stack_top; // [RULE2]
            next_mie = rre_pkg::MIE_ON; // [RULE2]
          end
        end
        rre_pkg::rre_op_rotate_left,
        rre_pkg::rre_op_rotate_right: begin
          next_mem_we = 1'b1; // [RULE4] [RULE8]
          next_mem_wdata = rot.dout; // [RULE4] [RULE8]
        end
        rre_pkg::rre_op_rotate_left_to_accumulator,
        rre_pkg::rre_op_rotate_right_to_accumulator: begin
          next_acc = rot.dout; // [RULE5] [RULE9]
        end
        rre_pkg::rre_op_rotate_left_through_carry,
        rre_pkg::rre_op_rotate_right_through_carry: begin
          next_mem_we = 1'b1; // [RULE6] [RULE10]
          next_mem_wdata = rot.dout; // [RULE6] [RULE10]
          next_carry = rot.cout; // [RULE6] [RULE10] [RULE11]
        end
        rre_pkg::rre_op_rotate_left_carry_to_accumulator: begin
          next_acc = rot.dout; // [RULE7]
          next_carry = rot.cout; // [RULE7] [RULE11]
        end
        default: begin
          // unassigned codes retire as no operation
          next_done = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_mem_we <= 1'b0;
      o_mem_wdata <= rre_pkg::ACC_RST;
      o_stack_push <= 1'b0;
      o_push_addr <= rre_pkg::PC_RST;
      o_acc <= rre_pkg::ACC_RST;
      o_carry <= rre_pkg::CARRY_RST;
      o_mie <= rre_pkg::MIE_RST;
      o_pc <= rre_pkg::PC_RST;
      o_done <= 1'b0;
    end else begin
      o_mem_we <= next_mem_we;
      o_mem_wdata <= next_mem_wdata;
      o_stack_push <= next_stack_push;
      o_push_addr <= next_push_addr;
      o_acc <= next_acc;
      o_carry <= next_carry;
      o_mie <= next_mie;
      o_pc <= next_pc;
      o_done <= next_done;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  a_lit_exit_load: assert property ( // [RULE1]
    take && op == rre_pkg::rre_op_subroutine_exit_with_literal |-> o_stack_pop ##1
    (o_acc == $past(i_literal) && o_pc == $past(i_stack_top) && $stable(o_carry) && !o_mem_we))
    else $error("literal exit did not load pc and accumulator");
  a_int_return_mie: assert property ( // [RULE2]
    take && op == rre_pkg::rre_op_return_from_interrupt && !i_irq_pending |=>
    o_mie && o_pc == $past(i_stack_top) && $stable(o_carry) && $stable(o_acc))
    else $error("interrupt return did not restore pc and enable");
  a_pending_entry: assert property ( // [RULE3]
    take && op == rre_pkg::rre_op_return_from_interrupt && i_irq_pending |=>
    o_pc == $past(i_irq_vector) && o_stack_push && o_push_addr == $past(i_stack_top) && !o_mie ##1
    (!o_stack_push || $past(take && op == rre_pkg::rre_op_return_from_interrupt && i_irq_pending)))
    else $error("pending interrupt not entered at interrupt return");
  a_rotl_mem: assert property ( // [RULE4]
    take && op == rre_pkg::rre_op_rotate_left |=>
    o_mem_we && o_mem_wdata == {$past(i_mem_rdata[6:0]), $past(i_mem_rdata[7])} && $stable(o_carry))
    else $error("rotate left wrote wrong byte");
  a_rotl_acc: assert property ( // [RULE5]
    take && op == rre_pkg::rre_op_rotate_left_to_accumulator |=>
    !o_mem_we && o_acc == {$past(i_mem_rdata[6:0]), $past(i_mem_rdata[7])} && $stable(o_carry))
    else $error("rotate left to accumulator wrong");
  a_rotlc_mem: assert property ( // [RULE6]
    take && op == rre_pkg::rre_op_rotate_left_through_carry |=>
    o_mem_we && o_mem_wdata == {$past(i_mem_rdata[6:0]), $past(o_carry)} && o_carry == $past(i_mem_rdata[7]))
    else $error("rotate left through carry wrong");
  a_rotlc_acc: assert property ( // [RULE7]
    take && op == rre_pkg::rre_op_rotate_left_carry_to_accumulator |=>
    !o_mem_we && o_acc == {$past(i_mem_rdata[6:0]), $past(o_carry)} && o_carry == $past(i_mem_rdata[7]))
    else $error("rotate left carry to accumulator wrong");
  a_rotr_mem: assert property ( // [RULE8]
    take && op == rre_pkg::rre_op_rotate_right |=>
    o_mem_we && o_mem_wdata == {$past(i_mem_rdata[0]), $past(i_mem_rdata[7:1])} && $stable(o_acc) &&
    $stable(o_carry))
    else $error("rotate right wrote wrong byte");
  a_rotr_acc: assert property ( // [RULE9]
    take && op == rre_pkg::rre_op_rotate_right_to_accumulator |=>
    !o_mem_we && o_acc == {$past(i_mem_rdata[0]), $past(i_mem_rdata[7:1])} && $stable(o_carry))
    else $error("rotate right to accumulator wrong");
  a_rotrc_mem: assert property ( // [RULE10]
    take && op == rre_pkg::rre_op_rotate_right_through_carry |=>
    o_mem_we && o_mem_wdata == {$past(o_carry), $past(i_mem_rdata[7:1])} && o_carry == $past(i_mem_rdata[0]))
    else $error("rotate right through carry wrong");
  a_thru_flags_only: assert property ( // [RULE11]
    take && is_thru(op) |=> $stable(o_mie) && $stable(o_pc) && !o_stack_push)
    else $error("through-carry rotate touched more than carry");
  // every code retires in one cycle, unassigned ones too, so the core sequencer never stalls here
  a_done_pulse: assert property (
    o_done == $past(i_op_valid && !i_sys_rst))
    else $error("done pulse does not follow a taken instruction");

  c_pending_entry: cover property (take && op == rre_pkg::rre_op_return_from_interrupt && i_irq_pending);
  c_carry_out: cover property (take && op == rre_pkg::rre_op_rotate_left_through_carry ##1 o_carry);
  c_back_to_back: cover property (take && is_thru(op) ##1 take && is_thru(op));
  c_lit_exit: cover property (take && op == rre_pkg::rre_op_subroutine_exit_with_literal);
  c_int_return_plain: cover property (take && op == rre_pkg::rre_op_return_from_interrupt && !i_irq_pending);
endmodule : rre_exec

/* src/rre_pkg.sv */
// package: opcodes, widths and reset values for the rotate and return execution block
package rre_pkg;
  localparam int DATA_W = 8;
  localparam int PC_W = 13;
  localparam int OP_W = 4;
  localparam int MSB_POS = 7;
  localparam int LSB_POS = 0;

  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic CARRY_RST = 1'b0;
  localparam logic MIE_RST = 1'b0;
  localparam logic MIE_ON = 1'b1;
  localparam logic [12:0] PC_RST = 13'h0000;

  typedef enum logic [3:0] {
    rre_op_nop = 4'b0000,
    rre_op_subroutine_exit_with_literal = 4'b0001,
    rre_op_return_from_interrupt = 4'b0010,
    rre_op_rotate_left = 4'b0011,
    rre_op_rotate_left_to_accumulator = 4'b0100,
    rre_op_rotate_left_through_carry = 4'b0101,
    rre_op_rotate_left_carry_to_accumulator = 4'b0110,
    rre_op_rotate_right = 4'b0111,
    rre_op_rotate_right_to_accumulator = 4'b1000,
    rre_op_rotate_right_through_carry = 4'b1001
  } rre_op_t;
endpackage : rre_pkg

/* src/rre_rot_if.sv */
// interface: operand and result of the byte rotator
`timescale 1ns/1ps
interface rre_rot_if;
  logic [7:0] din;
  logic cin;
  logic left;
  logic thru;
  logic [7:0] dout;
  logic cout;
  modport core (output din, output cin, output left, output thru, input dout, input cout);
  modport rot (input din, input cin, input left, input thru, output dout, output cout);
endinterface : rre_rot_if

/* src/rre_rotator.sv */
// module: one-bit byte rotator, plain or through carry
`timescale 1ns/1ps
module rre_rotator (
  rre_rot_if.rot port
);
  always_comb begin
    if (port.left) begin
      // msb leaves, carry or old msb enters at bit 0
      port.dout = {port.din[rre_pkg::MSB_POS-1:rre_pkg::LSB_POS], port.thru ? port.cin : port.din[rre_pkg::MSB_POS]};
      port.cout = port.thru ? port.din[rre_pkg::MSB_POS] : port.cin;
    end else begin
      port.dout = {port.thru ? port.cin : port.din[rre_pkg::LSB_POS], port.din[rre_pkg::MSB_POS:rre_pkg::LSB_POS+1]};
      port.cout = port.thru ? port.din[rre_pkg::LSB_POS] : port.cin;
    end
  end
endmodule : rre_rotator

/* tb/tb_top.sv */
// testbench: directed scenarios for the rotate and return execution block
`timescale 1ns/1ps
module tb_top;
  logic i_ref_clk, i_sys_rst, i_op_valid, i_irq_pending;
  logic [3:0] i_op_code;
  logic [7:0] i_literal, i_mem_rdata;
  logic [12:0] i_stack_top, i_irq_vector;
  logic o_mem_we, o_stack_pop, o_stack_push, o_carry, o_mie, o_done;
  logic [7:0] o_mem_wdata, o_acc;
  logic [12:0] o_push_addr, o_pc;
  int failures = 0;
  int n_checks = 0;

  rre_exec u_dut (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_op_valid(i_op_valid),
    .i_op_code(i_op_code), .i_literal(i_literal), .i_mem_rdata(i_mem_rdata), .o_mem_we(o_mem_we),
    .o_mem_wdata(o_mem_wdata), .i_stack_top(i_stack_top), .o_stack_pop(o_stack_pop),
    .o_stack_push(o_stack_push), .o_push_addr(o_push_addr), .i_irq_pending(i_irq_pending),
    .i_irq_vector(i_irq_vector), .o_acc(o_acc), .o_carry(o_carry), .o_mie(o_mie), .o_pc(o_pc),
    .o_done(o_done));

  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one instruction; pop is looked at in the taking cycle, results one cycle later
  task automatic issue(input rre_pkg::rre_op_t op, input logic [7:0] d, input logic [7:0] lit,
                       input logic irq, input logic [12:0] top);
    @(posedge i_ref_clk);
    i_op_valid <= 1'b1;
    i_op_code <= op;
    i_mem_rdata <= d;
    i_literal <= lit;
    i_irq_pending <= irq;
    i_stack_top <= top;
    #1;
    chk(o_stack_pop, (op == rre_pkg::rre_op_subroutine_exit_with_literal) ||
                     (op == rre_pkg::rre_op_return_from_interrupt));
    @(posedge i_ref_clk);
    i_op_valid <= 1'b0;
    i_irq_pending <= 1'b0;
    i_mem_rdata <= ~d; // operand no longer valid, so show something else
    #1;
    chk(o_done, 1'b1);
  endtask : issue

  task automatic t_reset;
    chk({o_acc, o_carry, o_mie, o_mem_we, o_stack_push, o_done}, 16'h0000);
    chk(o_pc, 16'h0000);
    $display("test reset done");
  endtask : t_reset

  // carry chain across successive through-carry rotates, one idle cycle apart
  task automatic t_carry_rot;
    issue(rre_pkg::rre_op_rotate_left_through_carry, 8'h81, 8'h00, 1'b0, 13'h0000);
    chk({o_mem_we, o_mem_wdata, o_carry, o_mie}, {1'b1, 8'h02, 1'b1, 1'b0});
    issue(rre_pkg::rre_op_rotate_left_carry_to_accumulator, 8'h01, 8'h00, 1'b0, 13'h0000);
    chk({o_mem_we, o_acc, o_carry}, {1'b0, 8'h03, 1'b0});
    issue(rre_pkg::rre_op_rotate_right_through_carry, 8'h01, 8'h00, 1'b0, 13'h0000);
    chk({o_mem_we, o_mem_wdata, o_carry, o_acc}, {1'b1, 8'h00, 1'b1, 8'h03});
    issue(rre_pkg::rre_op_rotate_right_through_carry, 8'h02, 8'h00, 1'b0, 13'h0000);
    chk({o_mem_we, o_mem_wdata, o_carry, o_mie}, {1'b1, 8'h81, 1'b0, 1'b0});
    $display("test carry rotates done");
  endtask : t_carry_rot

  // plain rotates with carry set beforehand, so a stray carry update shows
  task automatic t_plain_rot;
    rre_pkg::rre_op_t ops[4];
    logic [7:0] ex[4];
    ops = '{rre_pkg::rre_op_rotate_left, rre_pkg::rre_op_rotate_left_to_accumulator,
            rre_pkg::rre_op_rotate_right, rre_pkg::rre_op_rotate_right_to_accumulator};
    ex = '{8'h2D, 8'h2D, 8'h4B, 8'h4B};
    issue(rre_pkg::rre_op_rotate_left_through_carry, 8'h80, 8'h00, 1'b0, 13'h0000);
    for (int i = 0; i < 4; i++) begin
      issue(ops[i], 8'h96, 8'h00, 1'b0, 13'h0000);
      chk(o_carry, 1'b1);
      chk(o_mem_we, i % 2 == 0);
      chk(i % 2 == 0 ? o_mem_wdata : o_acc, ex[i]);
    end
    $display("test plain rotates done");
  endtask : t_plain_rot

  task automatic t_lit_exit;
    issue(rre_pkg::rre_op_subroutine_exit_with_literal, 8'h00, 8'hA5, 1'b0, 13'h1ABC);
    chk({o_acc, o_carry, o_mem_we}, {8'hA5, 1'b1, 1'b0});
    chk(o_pc, 16'h1ABC);
    $display("test literal exit done");
  endtask : t_lit_exit

  task automatic t_int_return;
    @(posedge i_ref_clk);
    i_irq_vector <= 13'h0123;
    issue(rre_pkg::rre_op_return_from_interrupt, 8'h00, 8'h00, 1'b0, 13'h0F0F);
    chk({o_pc, o_mie, o_carry}, {13'h0F0F, 1'b1, 1'b1});
    chk({o_acc, o_stack_push}, {8'hA5, 1'b0});
    issue(rre_pkg::rre_op_return_from_interrupt, 8'h00, 8'h00, 1'b1, 13'h0555);
    chk({o_pc, o_stack_push, o_mie}, {13'h0123, 1'b1, 1'b0});
    chk(o_push_addr, 16'h0555);
    @(posedge i_ref_clk);
    #1;
    chk({o_stack_push, o_done}, 2'b00);
    $display("test interrupt return done");
  endtask : t_int_return

  // reset with live state, an instruction right after release, then nop and an unassigned code
  task automatic t_mid_reset;
    @(posedge i_ref_clk);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    #1;
    chk({o_acc, o_carry, o_mie, o_mem_we, o_stack_push, o_done}, 16'h0000);
    chk(o_pc, 16'h0000);
    chk(o_push_addr, 16'h0000);
    chk(o_mem_wdata, 16'h0000);
    issue(rre_pkg::rre_op_rotate_left_carry_to_accumulator, 8'hC1, 8'h00, 1'b0, 13'h0000);
    chk({o_acc, o_carry, o_mem_we}, {8'h82, 1'b1, 1'b0});
    issue(rre_pkg::rre_op_nop, 8'hFF, 8'h5A, 1'b0, 13'h1FFF);
    issue(rre_pkg::rre_op_t'(4'hF), 8'hFF, 8'h5A, 1'b1, 13'h1FFF);
    chk({o_acc, o_carry, o_mie, o_mem_we, o_stack_push}, {8'h82, 1'b1, 1'b0, 1'b0, 1'b0});
    chk(o_pc, 16'h0000);
    $display("test mid-run reset and nop done");
  endtask : t_mid_reset

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  initial begin
    i_sys_rst = 1'b1;
    i_op_valid = 1'b0;
    i_op_code = 4'h0;
    i_literal = 8'h00;
    i_mem_rdata = 8'h00;
    i_stack_top = 13'h0000;
    i_irq_pending = 1'b0;
    i_irq_vector = 13'h0000;
    repeat (16) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_ref_clk);
    #1;
    t_reset();
    t_carry_rot();
    t_plain_rot();
    t_lit_exit();
    t_int_return();
    t_mid_reset();
    give_verdict();
  end

  // the whole run needs well under a hundred cycles
  initial begin
    repeat (2000) @(posedge i_ref_clk);
    failures++;
    give_verdict();
  end
endmodule : tb_top
